// ---- logic/ccal_top.sv ----
`timescale 1ns/100ps
// What this block does
// RULE_01 - phase field is signed two's complement, offset in modulator cycles
// RULE_02 - every channel has its own ten-bit phase field
// RULE_03 - each result comes from exactly one ratio count of consecutive samples; the first result after reset counts only samples since reset
// RULE_04 - with equal phases all channel windows line up in time
// RULE_05 - ratios up to 1024 accept minus half ratio to half ratio minus one
// RULE_06 - ratios above 1024 limit phase to minus 512 through 511
// RULE_07 - out-of-range phase saturates to nearest limit, never wraps
// RULE_08 - smallest ratio limits phase to minus 32 through 31
// RULE_09 - data-ready timing follows the applied channel phases
// RULE_10 - host does whole-sample shifts by index, device only the remainder
// RULE_11 - positive phase starts window later, negative earlier than reference
module ccal_top (
  input wire logic clock,
  input wire logic srst,
  input wire logic [ccal_pkg::CODE_W-1:0] decimation_ratio,
  input wire logic [ccal_pkg::NUM_CH*ccal_pkg::PHASE_W-1:0] channel_phase_offset,
  input wire logic [ccal_pkg::NUM_CH-1:0] mod_bits,
  input wire logic out_ready,
  output ccal_pkg::ccal_frame_t out_frame,
  output logic out_valid,
  output logic sample_available_n,
  output logic mod_tick_out
);
  // ************************************************************
  // modulator rate enable
  // ************************************************************
  logic [7:0] div_q, div_d;
  logic tick_q, tick_d;

  always_comb begin
    tick_d = 1'b0;
    div_d = div_q + 8'h01;
    if (div_q == ccal_pkg::MOD_DIV_LAST) begin
      div_d = 8'h00;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      div_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
    end
  end

  // ************************************************************
  // reference window counter and phase clipping
  // ************************************************************
  logic [ccal_pkg::CNT_W-1:0] ratio, half, lim, ref_q, ref_d;
  logic [ccal_pkg::CODE_W-1:0] code;
  logic signed [ccal_pkg::CNT_W:0] lo, hi;
  logic [ccal_pkg::NUM_CH-1:0] boundary;

  always_comb begin
    // unsupported codes fall back to the largest ratio
    code = (decimation_ratio > ccal_pkg::RATIO_CODE_MAX) ?
           ccal_pkg::RATIO_CODE_MAX : decimation_ratio;
    ratio = ccal_pkg::RATIO_MIN << code;
    half = ratio >> 1;
    lim = (half > ccal_pkg::HALF_CAP) ? ccal_pkg::HALF_CAP : half; // [RULE_05] [RULE_06] [RULE_08]
    lo = -$signed({1'b0, lim});
    hi = $signed({1'b0, lim}) - 16'sd1;
  end

  always_comb begin
    ref_d = ref_q;
    if (tick_q) begin
      ref_d = (ref_q >= ratio - 15'h0001) ? '0 : ref_q + 15'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      ref_q <= '0;
    end else begin
      ref_q <= ref_d;
    end
  end

  // ************************************************************
  // per-channel windows
  // ************************************************************
  logic [ccal_pkg::ACC_W-1:0] res [ccal_pkg::NUM_CH];
  logic [ccal_pkg::NUM_CH-1:0] res_vld;

  for (genvar c = 0; c < ccal_pkg::NUM_CH; c++) begin : g_ch
    ccal_pkg::ccal_phase_t raw;
    logic signed [ccal_pkg::CNT_W:0] wide, applied;
    logic [ccal_pkg::CNT_W-1:0] start;

    always_comb begin
      raw = channel_phase_offset[c*ccal_pkg::PHASE_W +: ccal_pkg::PHASE_W]; // [RULE_02]
      wide = 16'(raw); // [RULE_01]
      applied = wide;
      if (wide < lo) begin
        applied = lo; // [RULE_07]
      end else if (wide > hi) begin
        applied = hi; // [RULE_07]
      end
      // window starts at reference plus applied phase, modulo the ratio
      start = (15'(applied) + ratio) & (ratio - 15'h0001); // [RULE_11]
      boundary[c] = (ref_q == start); // [RULE_04]
    end

    ccal_chan u_chan (
      .clock(clock),
      .srst(srst),
      .mod_tick(tick_q),
      .mod_bit(mod_bits[c]),
      .boundary(boundary[c]),
      .result(res[c]),
      .result_valid(res_vld[c])
    );
  end

  // ************************************************************
  // frame gather: ready only once every channel window has closed
  // ************************************************************
  logic [ccal_pkg::NUM_CH-1:0] done_q, done_d;
  logic push;
  ccal_pkg::ccal_frame_t frame_in;
  logic tv_q, tv_d, hv_q, hv_d, in_ready;

  assign frame_in = '{ch2: res[2], ch1: res[1], ch0: res[0]};
  assign in_ready = !tv_q;

  always_comb begin
    // latest channel to close sets the frame moment, so phases move it
    push = (&(done_q | res_vld)) && in_ready; // [RULE_09]
    done_d = done_q | res_vld;
    if (push) begin
      done_d = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      done_q <= '0;
    end else begin
      done_q <= done_d;
    end
  end

  // ************************************************************
  // two-entry buffer, head drives the outputs
  // ************************************************************
  ccal_pkg::ccal_frame_t head_q, head_d, tail_q, tail_d;
  logic pop, rdy_n_q, rdy_n_d;

  always_comb begin
    pop = hv_q && out_ready;
    head_d = head_q;
    tail_d = tail_q;
    hv_d = hv_q;
    tv_d = tv_q;
    if (pop) begin
      if (tv_q) begin
        head_d = tail_q;
        tv_d = 1'b0;
        if (push) begin
          tail_d = frame_in;
          tv_d = 1'b1;
        end
      end else if (push) begin
        head_d = frame_in;
      end else begin
        hv_d = 1'b0;
      end
    end else if (push) begin
      if (hv_q) begin
        tail_d = frame_in;
        tv_d = 1'b1;
      end else begin
        head_d = frame_in;
        hv_d = 1'b1;
      end
    end
    rdy_n_d = !hv_d; // [RULE_09]
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      head_q <= '0;
      tail_q <= '0;
      hv_q <= 1'b0;
      tv_q <= 1'b0;
      rdy_n_q <= 1'b1;
    end else begin
      head_q <= head_d;
      tail_q <= tail_d;
      hv_q <= hv_d;
      tv_q <= tv_d;
      rdy_n_q <= rdy_n_d;
    end
  end

  assign out_frame = head_q;
  assign out_valid = hv_q;
  assign sample_available_n = rdy_n_q;
  assign mod_tick_out = tick_q;
endmodule // ccal_top

// ---- logic/ccal_pkg.sv ----
package ccal_pkg;
  localparam int NUM_CH = 3;
  localparam int PHASE_W = 10;
  localparam int ACC_W = 16;
  localparam int CNT_W = 15;
  localparam int CODE_W = 4;
  // system clock rate and the modulator sample rate derived from it
  localparam int CLK_HZ = 25000000;
  localparam int MOD_HZ = 2083333;
  localparam int MOD_DIV = CLK_HZ / MOD_HZ;
  localparam logic [7:0] MOD_DIV_LAST = 8'(MOD_DIV - 1);
  // decimation ratio codes, ratio = 64 << code
  localparam logic [CODE_W-1:0] RATIO_CODE_MAX = 4'h8;
  localparam logic [CNT_W-1:0] RATIO_MIN = 15'h0040;
  // half of ratio 1024, the largest ratio that still clips to half the ratio
  localparam logic [CNT_W-1:0] HALF_CAP = 15'h0200;
  localparam logic [PHASE_W-1:0] PHASE_ZERO = 10'h000;

  typedef logic signed [PHASE_W-1:0] ccal_phase_t;

  typedef struct packed {
    logic [ACC_W-1:0] ch2;
    logic [ACC_W-1:0] ch1;
    logic [ACC_W-1:0] ch0;
  } ccal_frame_t;
endpackage

// ---- logic/ccal_chan.sv ----
`timescale 1ns/100ps
// one decimation window per channel: counts modulator ones over one ratio count
module ccal_chan (
  input wire logic clock,
  input wire logic srst,
  input wire logic mod_tick,
  input wire logic mod_bit,
  input wire logic boundary,
  output logic [ccal_pkg::ACC_W-1:0] result,
  output logic result_valid
);
  logic [ccal_pkg::ACC_W-1:0] acc_q, acc_d, res_q, res_d;
  logic vld_q, vld_d;

  always_comb begin
    acc_d = acc_q;
    res_d = res_q;
    vld_d = 1'b0;
    if (mod_tick) begin
      if (boundary) begin
        // window closes: samples since the last boundary, or since reset, become the result
        res_d = acc_q; // [RULE_03]
        vld_d = 1'b1;
        acc_d = {{(ccal_pkg::ACC_W-1){1'b0}}, mod_bit};
      end else begin
        acc_d = acc_q + {{(ccal_pkg::ACC_W-1){1'b0}}, mod_bit};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      acc_q <= '0;
      res_q <= '0;
      vld_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      res_q <= res_d;
      vld_q <= vld_d;
    end
  end

  assign result = res_q;
  assign result_valid = vld_q;
endmodule // ccal_chan

// ---- testbench/ccal_properties.sv ----
`timescale 1ns/100ps
module ccal_props (
  input wire logic clock,
  input wire logic srst,
  input wire ccal_pkg::ccal_frame_t out_frame,
  input wire logic out_ready,
  input wire logic out_valid,
  input wire logic sample_available_n,
  input wire logic mod_tick_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  a_ready_mirror: assert property (sample_available_n == !out_valid)
    else $error("data ready does not mirror valid");
  a_frame_holds: assert property (out_valid && !out_ready |=> out_valid && $stable(out_frame))
    else $error("held frame changed");
  a_tick_period: assert property (mod_tick_out |-> ##12 mod_tick_out)
    else $error("tick period wrong");
  a_tick_gap: assert property (mod_tick_out |=> !mod_tick_out [*8])
    else $error("tick too soon");
  a_count_bound: assert property (out_valid |-> out_frame.ch0 <= 16'h4000 &&
    out_frame.ch1 <= 16'h4000 && out_frame.ch2 <= 16'h4000)
    else $error("count above largest window");
  a_first_tick: assert property ($fell(srst) |-> !mod_tick_out [*8])
    else $error("tick too early after reset");
  a_reset_idle: assert property (disable iff (1'b0) srst |=> !out_valid && sample_available_n)
    else $error("reset did not idle outputs");
  a_reset_frame: assert property (disable iff (1'b0) srst |=> out_frame == '0 && !mod_tick_out)
    else $error("reset did not clear frame");
endmodule // ccal_props

// ---- testbench/ccal_host.sv ----
`timescale 1ns/100ps
module ccal_host (
  input wire logic clock,
  input wire logic srst,
  input wire logic stall,
  output logic out_ready
);
  logic [1:0] pace_q;
  // slow reader, three cycles of four, so back-pressure is always present
  always_ff @(posedge clock) begin
    pace_q <= srst ? 2'h0 : pace_q + 2'h1;
    out_ready <= !srst && !stall && pace_q != 2'h0;
  end
endmodule // ccal_host

// ---- testbench/channel_phase_calibration_test.sv ----
`timescale 1ns/100ps
module channel_phase_calibration_test;
  logic clock = 0;
  logic srst = 1;
  logic stall = 0;
  logic out_ready;
  logic [3:0] decimation_ratio = 4'h0;
  logic [29:0] channel_phase_offset = '0;
  logic [2:0] mod_bits = '0;
  ccal_pkg::ccal_frame_t out_frame;
  logic out_valid, sample_available_n, mod_tick_out;
  int mismatches = 0;
  int samples_checked = 0;
  int ticks = 0;
  always #20 clock = ~clock;
  ccal_top dut (.clock, .srst, .decimation_ratio, .channel_phase_offset, .mod_bits, .out_ready,
    .out_frame, .out_valid, .sample_available_n, .mod_tick_out);
  ccal_host host (.clock, .srst, .stall, .out_ready);
  // input steps to ones mid-window, so each channel's window position shows in one count
  always @(posedge clock) begin
    ticks <= srst ? 0 : ticks + int'(mod_tick_out === 1'b1);
    mod_bits <= (ticks >= 300) ? 3'h7 : 3'h0;
  end
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (e !== g) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // kl: tick index at which the latest channel window first closes after reset
  task automatic s_phase(logic [3:0] code, logic [29:0] ph, int e0, int e1, int kl, bit st);
    logic [15:0] v [3];
    logic [15:0] r, m, w;
    bit seen [3];
    ccal_pkg::ccal_frame_t last;
    int fall;
    r = 16'h0040 << code;
    m = r - 16'h0001;
    seen = '{0, 0, 0};
    fall = -1;
    @(posedge clock);
    srst <= 1;
    decimation_ratio <= code;
    channel_phase_offset <= ph;
    stall <= st;
    repeat (2) @(posedge clock);
    srst <= 0;
    for (int i = 0; i < 96 * r; i++) begin
      @(negedge clock);
      if (i == 18 * r) stall <= 0;
      if (fall < 0 && sample_available_n === 1'b0) fall = i;
      if (out_valid === 1'b1 && out_ready === 1'b1) begin
        last = out_frame;
        for (int c = 0; c < 3; c++) begin
          w = out_frame[16*c +: 16];
          if (!seen[c] && w !== 16'h0 && w !== r) begin
            v[c] = w;
            seen[c] = 1;
          end
        end
      end
    end
    chk("ch0 shift", 16'(e0) & m, (v[0] - v[2]) & m);
    chk("ch1 shift", 16'(e1) & m, (v[1] - v[2]) & m);
    for (int c = 0; c < 3; c++) chk("full window", r, last[16*c +: 16]);
    // first tick lands 12 clocks after release, frame shows two clocks after the closing tick
    chk("ready fall", 16'(14 + ccal_pkg::MOD_DIV * kl), 16'(fall));
  endtask
  // large ratio: only the first data-ready fall is timed, a full step run would take too long
  task automatic s_large();
    int fall;
    fall = -1;
    @(posedge clock);
    srst <= 1;
    decimation_ratio <= 4'h5;
    channel_phase_offset <= {10'h000, 10'h200, 10'h1ff};
    repeat (2) @(posedge clock);
    srst <= 0;
    for (int i = 0; i < 20000 && fall < 0; i++) begin
      @(negedge clock);
      if (sample_available_n === 1'b0) fall = i;
    end
    chk("wide ratio ready", 16'(14 + ccal_pkg::MOD_DIV * 1536), 16'(fall));
  endtask
  task automatic complete_run();
    if (mismatches == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clock);
    s_phase(4'h1, {10'h000, 10'h064, 10'h3f6}, -10, 63, 118, 0);
    s_phase(4'h0, {10'h000, 10'h200, 10'h01f}, 31, -32, 32, 0);
    s_phase(4'h2, 30'h0, 0, 0, 0, 1);
    s_large();
    complete_run();
  end
  initial begin
    #(40 * 80000);
    mismatches++;
    complete_run();
  end
endmodule // channel_phase_calibration_test
bind ccal_top ccal_props chk (.clock, .srst, .out_frame, .out_ready, .out_valid,
  .sample_available_n, .mod_tick_out);
